// ===== verilog/rtd_ring_trip.sv
// Ring trip detector with ringing common mode and current limit boost
// Overview of operation
// - Loop current samples are processed only while the linefeed field reads ringing.
// - Samples pass a low-pass filter with a programmable 13-bit coefficient first.
// - The filter output is compared against a 6-bit threshold feeding the debouncer.
// - The debouncer flips only after its input holds the opposite level for the interval.
// - A satisfied debounce sets the read-only trip status bit.
// - A trip sets the pending bit and drives the interrupt only when enabled.
// - During ringing the common mode is held at battery minus headroom.
// - The headroom is a 4-bit indirect field in 1.5 V steps.
// - With boost enabled the current limit is raised briefly on leaving ringing.
// - Writing the linefeed field with 100b enters ringing.
`timescale 1ns/100ps
module rtd_ring_trip
  import rtd_pkg::*;
#(
  parameter int BOOST_LEN = BOOST_CYCLES
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire rtd_reg_req_s regReq,
  output logic [15:0] regRdData,
  output logic regRdValid,
  // Loop current sense
  input wire logic [SENSE_W-1:0] loopCurrentSense,
  input wire logic loopCurrentValid,
  // Line control outputs
  output logic [LINEFEED_W-1:0] linefeedControl,
  output logic [VBAT_W-1:0] ringingCommonMode,
  output logic currentLimitBoost,
  output logic tripIrq
);
  logic rstSync1;
  logic rstN;
  logic [7:0] irqEnable;
  logic irqPending;
  logic [DEB_W-1:0] debInterval;
  logic [VBAT_W-1:0] highBattery;
  logic [7:0] boostCtrl;
  logic [15:0] indThreshold;
  logic [15:0] indFilter;
  logic [15:0] indHeadroom;
  logic [ACC_W-1:0] filtAcc;
  logic aboveThr;
  logic tripStatus;
  logic tripPrev;
  logic tripEvent;
  logic ringing;
  logic ringPrev;
  logic [31:0] boostCount;
  logic sampleEn;
  logic wrDirect;
  logic wrIndirect;
  logic signed [ACC_W+1:0] diff;
  logic signed [ACC_W+COEFF_W+2:0] prod;
  logic [ACC_W-1:0] next_filtAcc;
  logic [VBAT_W-1:0] next_common;

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstSync1 <= 1'b0;
      rstN <= 1'b0;
    end
    else
    begin
      rstSync1 <= 1'b1;
      rstN <= rstSync1;
    end
  end

  assign wrDirect = regReq.wrEn && !regReq.indirect;
  assign wrIndirect = regReq.wrEn && regReq.indirect;
  assign ringing = isRinging(linefeedControl);

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
      linefeedControl <= '0;
    else if (wrDirect && regReq.addr == OFS_LINEFEED)
      linefeedControl <= regReq.wrData[LINEFEED_W-1:0];
  end

  // Direct configuration registers
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      irqEnable <= RST_BYTE;
      debInterval <= '0;
      highBattery <= '0;
      boostCtrl <= RST_BYTE;
    end
    else if (wrDirect)
    begin
      case (regReq.addr)
        OFS_IRQ_ENABLE_TWO: irqEnable <= regReq.wrData[7:0];
        OFS_TRIP_DEBOUNCE: debInterval <= regReq.wrData[DEB_W-1:0];
        OFS_HIGH_BATTERY: highBattery <= regReq.wrData[VBAT_W-1:0];
        OFS_BOOST_CTRL: boostCtrl <= regReq.wrData[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      indThreshold <= RST_WORD;
      indFilter <= RST_WORD;
      indHeadroom <= RST_WORD;
    end
    else if (wrIndirect)
    begin
      case (regReq.addr)
        OFS_IND_THRESHOLD: indThreshold <= regReq.wrData;
        OFS_IND_FILTER: indFilter <= regReq.wrData;
        OFS_IND_HEADROOM: indHeadroom <= regReq.wrData;
        default: ;
      endcase
    end
  end

  // One step per sample, only while ringing
  assign sampleEn = loopCurrentValid && ringing;

  always_comb
  begin
    diff = $signed({2'b00, loopCurrentSense, 16'h0000}) - $signed({2'b00, filtAcc});
    prod = diff * $signed({1'b0, indFilter[COEFF_W-1:0]});
    next_filtAcc = filtAcc + prod[ACC_W+COEFF_W-1:COEFF_W];
  end

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
      filtAcc <= '0;
    else if (!ringing)
      filtAcc <= '0;
    else if (sampleEn)
      filtAcc <= next_filtAcc;
  end

  assign aboveThr = filtAcc[ACC_W-1:ACC_W-SENSE_W] >=
    {2'b00, indThreshold[THR_LSB+THR_W-1:THR_LSB]};

  rtd_debounce u_debounce (
    .clk(core_clk),
    .rstN(rstN),
    .clear(!ringing),
    .sampleEn(sampleEn),
    .interval(debInterval),
    .din(aboveThr),
    .dout(tripStatus)
  );

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
      tripPrev <= 1'b0;
    else
      tripPrev <= tripStatus;
  end
  assign tripEvent = tripStatus && !tripPrev;

  // Pending held until write-one clear, set wins
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
      irqPending <= 1'b0;
    else if (tripEvent)
      irqPending <= 1'b1;
    else if (wrDirect && regReq.addr == OFS_IRQ_PENDING_TWO && regReq.wrData[TRIP_IRQ_BIT])
      irqPending <= 1'b0;
  end

  assign tripIrq = irqPending && irqEnable[TRIP_IRQ_BIT];

  // Common mode in 1.5 V steps, battery minus headroom
  always_comb
  begin
    if (highBattery > {2'b00, indHeadroom[HEAD_W-1:0]})
      next_common = highBattery - {2'b00, indHeadroom[HEAD_W-1:0]};
    else
      next_common = '0;
  end

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
      ringingCommonMode <= '0;
    else if (ringing)
      ringingCommonMode <= next_common;
  end

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      ringPrev <= 1'b0;
      boostCount <= '0;
      currentLimitBoost <= 1'b0;
    end
    else
    begin
      ringPrev <= ringing;
      if (ringPrev && !ringing && boostCtrl[BOOST_EN_BIT])
      begin
        boostCount <= 32'(BOOST_LEN - 1);
        currentLimitBoost <= 1'b1;
      end
      else if (boostCount != '0)
        boostCount <= boostCount - 32'h1;
      else
        currentLimitBoost <= 1'b0;
    end
  end

  // Register readback, one cycle after the read strobe
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      regRdData <= RST_WORD;
      regRdValid <= 1'b0;
    end
    else
    begin
      regRdValid <= regReq.rdEn;
      regRdData <= RST_WORD;
      if (regReq.rdEn && regReq.indirect)
      begin
        case (regReq.addr)
          OFS_IND_THRESHOLD: regRdData <= 16'(indThreshold[THR_LSB+THR_W-1:THR_LSB]) << THR_LSB;
          OFS_IND_FILTER: regRdData <= 16'(indFilter[COEFF_W-1:0]);
          OFS_IND_HEADROOM: regRdData <= 16'(indHeadroom[HEAD_W-1:0]);
          default: regRdData <= RST_WORD;
        endcase
      end
      else if (regReq.rdEn)
      begin
        case (regReq.addr)
          OFS_IRQ_PENDING_TWO: regRdData <= 16'(irqPending) << TRIP_IRQ_BIT;
          OFS_IRQ_ENABLE_TWO: regRdData <= 16'(irqEnable[TRIP_IRQ_BIT]) << TRIP_IRQ_BIT;
          OFS_LINEFEED: regRdData <= {13'h0000, linefeedControl};
          OFS_LOOP_STATUS: regRdData <= 16'(tripStatus) << TRIP_STATUS_BIT;
          OFS_TRIP_DEBOUNCE: regRdData <= {9'h000, debInterval};
          OFS_HIGH_BATTERY: regRdData <= {10'h000, highBattery};
          OFS_BOOST_CTRL: regRdData <= 16'(boostCtrl[BOOST_EN_BIT]) << BOOST_EN_BIT;
          default: regRdData <= RST_WORD;
        endcase
      end
    end
  end

  a_trip_sets_pend: assert property (@(posedge core_clk) disable iff (!rstN)
    tripEvent |=> irqPending)
    else $error("Trip did not set pending bit");
  a_irq_needs_en: assert property (@(posedge core_clk) disable iff (!rstN)
    tripIrq |-> irqEnable[TRIP_IRQ_BIT] && irqPending)
    else $error("Interrupt raised without enable");
  a_pend_sticky: assert property (@(posedge core_clk) disable iff (!rstN)
    (irqPending && !(wrDirect && regReq.addr == OFS_IRQ_PENDING_TWO)) |=> irqPending)
    else $error("Pending bit dropped without a clear");
  a_pend_clear: assert property (@(posedge core_clk) disable iff (!rstN)
    (wrDirect && regReq.addr == OFS_IRQ_PENDING_TWO && regReq.wrData[0] && !tripEvent)
    |=> !irqPending)
    else $error("Pending bit not cleared by write");
  a_idle_no_filter: assert property (@(posedge core_clk) disable iff (!rstN)
    !ringing |=> filtAcc == '0)
    else $error("Filter active outside ringing");
  a_status_ringing: assert property (@(posedge core_clk) disable iff (!rstN)
    tripStatus |-> $past(ringing))
    else $error("Trip status outside ringing");
  a_filter_step: assert property (@(posedge core_clk) disable iff (!rstN)
    (ringing && !loopCurrentValid) |=> $stable(filtAcc))
    else $error("Filter moved without a sample");
  a_common_mode: assert property (@(posedge core_clk) disable iff (!rstN)
    ringing |=> ringingCommonMode == $past(next_common))
    else $error("Ringing common mode wrong");
  a_boost_start: assert property (@(posedge core_clk) disable iff (!rstN)
    (ringPrev && !ringing && boostCtrl[BOOST_EN_BIT]) |=> currentLimitBoost [*2])
    else $error("Boost did not start on ringing exit");
  a_linefeed_wr: assert property (@(posedge core_clk) disable iff (!rstN)
    (wrDirect && regReq.addr == OFS_LINEFEED && regReq.wrData[2:0] == LF_RINGING)
    |=> ringing)
    else $error("Ringing not entered on linefeed write");
endmodule

// ===== verilog/rtd_pkg.sv
// Package with register map, field layout and timing for the ring trip detector
package rtd_pkg;
  // Direct register offsets
  localparam logic [7:0] OFS_IRQ_PENDING_TWO = 8'h13;
  localparam logic [7:0] OFS_IRQ_ENABLE_TWO = 8'h16;
  localparam logic [7:0] OFS_LINEFEED = 8'h40;
  localparam logic [7:0] OFS_LOOP_STATUS = 8'h44;
  localparam logic [7:0] OFS_TRIP_DEBOUNCE = 8'h46;
  localparam logic [7:0] OFS_HIGH_BATTERY = 8'h4a;
  localparam logic [7:0] OFS_BOOST_CTRL = 8'h6c;
  // Indirect register offsets
  localparam logic [7:0] OFS_IND_THRESHOLD = 8'h1d;
  localparam logic [7:0] OFS_IND_FILTER = 8'h24;
  localparam logic [7:0] OFS_IND_HEADROOM = 8'h28;
  // Field positions
  localparam int TRIP_IRQ_BIT = 0;
  localparam int TRIP_STATUS_BIT = 0;
  localparam int BOOST_EN_BIT = 7;
  localparam int THR_LSB = 8;
  localparam int THR_W = 6;
  localparam int COEFF_W = 13;
  localparam int DEB_W = 7;
  localparam int LINEFEED_W = 3;
  localparam int VBAT_W = 6;
  localparam int HEAD_W = 4;
  localparam int SENSE_W = 8;
  localparam int ACC_W = 24;
  // Linefeed code for the ringing state
  localparam logic [2:0] LF_RINGING = 3'h4;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // Boost window length
  localparam int CLK_MHZ = 125;
  localparam int BOOST_US = 1000;
  localparam int BOOST_CYCLES = BOOST_US * CLK_MHZ;

  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic indirect;
    logic [7:0] addr;
    logic [15:0] wrData;
  } rtd_reg_req_s;

  function automatic logic isRinging(input logic [2:0] code);
    return code == LF_RINGING;
  endfunction
endpackage

// ===== verilog/rtd_debounce.sv
// Debounce stage that flips only after a steady opposite input
`timescale 1ns/100ps
module rtd_debounce
  import rtd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstN,
  // Control
  input wire logic clear,
  input wire logic sampleEn,
  input wire logic [DEB_W-1:0] interval,
  // Data
  input wire logic din,
  output logic dout
);
  logic [DEB_W-1:0] count;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      count <= '0;
      dout <= 1'b0;
    end
    else if (clear)
    begin
      count <= '0;
      dout <= 1'b0;
    end
    else if (sampleEn)
    begin
      if (din == dout)
        count <= '0;
      else if (count >= interval)
      begin
        dout <= din;
        count <= '0;
      end
      else
        count <= count + 7'h01;
    end
  end

  a_deb_flip_time: assert property (@(posedge clk) disable iff (!rstN)
    (!$past(clear) && $changed(dout)) |-> $past(sampleEn) && $past(count) >= $past(interval))
    else $error("Debounce output changed before interval elapsed");
endmodule

// ===== tb/rtd_line_model.sv
// Subscriber line model that streams loop current samples
`timescale 1ns/100ps
module rtd_line_model
  import rtd_pkg::*;
(
  // Clock
  input wire logic clk,
  // Sample link
  output logic [SENSE_W-1:0] loopCurrentSense,
  output logic loopCurrentValid
);
  initial
  begin
    loopCurrentSense = 8'h00;
    loopCurrentValid = 1'b0;
  end

  task automatic send(input logic [SENSE_W-1:0] level, input int n);
    repeat (n)
    begin
      @(posedge clk);
      loopCurrentSense <= level;
      loopCurrentValid <= 1'b1;
    end
    @(posedge clk);
    loopCurrentValid <= 1'b0;
    loopCurrentSense <= ~level;
  endtask
endmodule

// ===== tb/rtd_ring_trip_bench.sv
// Self-checking bench for the ring trip detector
`timescale 1ns/100ps
module rtd_ring_trip_bench
  import rtd_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  rtd_reg_req_s regReq = '0;
  logic [15:0] regRdData;
  logic regRdValid;
  logic [SENSE_W-1:0] loopCurrentSense;
  logic loopCurrentValid;
  logic [LINEFEED_W-1:0] linefeedControl;
  logic [VBAT_W-1:0] ringingCommonMode;
  logic currentLimitBoost;
  logic tripIrq;
  int errors = 0;
  int cmpCount = 0;
  int n;
  logic [15:0] rd;
  // Rows: indirect, offset, readback after writing all ones
  localparam logic [24:0] ROWS [12] = '{
    {1'b0, 8'h13, 16'h0000}, {1'b0, 8'h16, 16'h0001}, {1'b0, 8'h40, 16'h0007},
    {1'b0, 8'h44, 16'h0000}, {1'b0, 8'h46, 16'h007f}, {1'b0, 8'h4a, 16'h003f},
    {1'b0, 8'h6c, 16'h0080}, {1'b1, 8'h1d, 16'h3f00}, {1'b1, 8'h24, 16'h1fff},
    {1'b1, 8'h28, 16'h000f}, {1'b0, 8'h55, 16'h0000}, {1'b1, 8'h30, 16'h0000}};

  always #4 core_clk = ~core_clk;

  rtd_ring_trip #(.BOOST_LEN(8)) dut (.core_clk(core_clk), .rst_n(rst_n), .regReq(regReq),
    .regRdData(regRdData), .regRdValid(regRdValid), .loopCurrentSense(loopCurrentSense),
    .loopCurrentValid(loopCurrentValid), .linefeedControl(linefeedControl),
    .ringingCommonMode(ringingCommonMode), .currentLimitBoost(currentLimitBoost),
    .tripIrq(tripIrq));

  rtd_line_model line (.clk(core_clk), .loopCurrentSense(loopCurrentSense),
    .loopCurrentValid(loopCurrentValid));

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmpCount, errors);
    if (errors == 0 && cmpCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chkVal(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmpCount++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chkBit(input string name, input logic exp, input logic got);
    cmpCount++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic regWrite(input logic ind, input logic [7:0] addr, input logic [15:0] data);
    @(posedge core_clk);
    regReq <= '{wrEn: 1'b1, rdEn: 1'b0, indirect: ind, addr: addr, wrData: data};
    @(posedge core_clk);
    regReq <= '0;
  endtask

  task automatic regRead(input logic ind, input logic [7:0] addr, output logic [15:0] data);
    int i;
    @(posedge core_clk);
    regReq <= '{wrEn: 1'b0, rdEn: 1'b1, indirect: ind, addr: addr, wrData: 16'h0000};
    @(posedge core_clk);
    regReq <= '0;
    for (i = 0; i < 4; i++)
    begin
      #1;
      if (regRdValid === 1'b1)
        break;
      @(posedge core_clk);
    end
    data = regRdData;
    if (regRdValid !== 1'b1)
    begin
      errors++;
      $display("[ERR] read valid expected 1 seen %b", regRdValid);
      summarize();
    end
  endtask

  task automatic status(input logic exp);
    logic [15:0] v;
    regRead(1'b0, OFS_LOOP_STATUS, v);
    chkBit("trip status", exp, v[TRIP_STATUS_BIT]);
  endtask

  task automatic arm(input logic [15:0] cf, input logic [15:0] th, input logic [15:0] db,
    input logic [2:0] mode);
    regWrite(1'b0, OFS_LINEFEED, 16'h0000);
    regWrite(1'b1, OFS_IND_FILTER, cf);
    regWrite(1'b1, OFS_IND_THRESHOLD, th);
    regWrite(1'b0, OFS_TRIP_DEBOUNCE, db);
    regWrite(1'b0, OFS_LINEFEED, {13'h0000, mode});
  endtask

  task automatic countBoost(output int cnt);
    cnt = 0;
    repeat (20)
    begin
      @(posedge core_clk);
      #1;
      if (currentLimitBoost === 1'b1)
        cnt++;
    end
  endtask

  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (int r = 0; r < 12; r++)
    begin
      regRead(ROWS[r][24], ROWS[r][23:16], rd);
      chkVal("reset value", 16'h0000, rd);
      regWrite(ROWS[r][24], ROWS[r][23:16], 16'hffff);
      regRead(ROWS[r][24], ROWS[r][23:16], rd);
      chkVal("readback", ROWS[r][15:0], rd);
    end
    // Common mode follows battery and headroom while ringing
    regWrite(1'b0, OFS_HIGH_BATTERY, 16'h0028);
    regWrite(1'b1, OFS_IND_HEADROOM, 16'h0005);
    regWrite(1'b0, OFS_LINEFEED, {13'h0000, LF_RINGING});
    repeat (3) @(posedge core_clk);
    #1;
    chkVal("linefeed", 16'h0004, {13'h0000, linefeedControl});
    chkVal("common mode", 16'h0023, {10'h000, ringingCommonMode});
    regWrite(1'b0, OFS_HIGH_BATTERY, 16'h0003);
    regWrite(1'b1, OFS_IND_HEADROOM, 16'h000f);
    repeat (3) @(posedge core_clk);
    #1;
    chkVal("common mode floor", 16'h0000, {10'h000, ringingCommonMode});
    regWrite(1'b0, OFS_LINEFEED, 16'h0000);
    regWrite(1'b0, OFS_HIGH_BATTERY, 16'h0028);
    repeat (3) @(posedge core_clk);
    #1;
    chkVal("common mode hold", 16'h0000, {10'h000, ringingCommonMode});
    // Debounce counting and interrupt path
    regWrite(1'b0, OFS_IRQ_ENABLE_TWO, 16'h0000);
    arm(16'h1fff, 16'h3600, 16'h0003, 3'h0);
    line.send(8'hff, 10);
    status(1'b0);
    regWrite(1'b0, OFS_LINEFEED, {13'h0000, LF_RINGING});
    line.send(8'hff, 3);
    status(1'b0);
    line.send(8'h00, 1);
    line.send(8'hff, 3);
    status(1'b0);
    line.send(8'hff, 2);
    status(1'b1);
    regRead(1'b0, OFS_IRQ_PENDING_TWO, rd);
    chkVal("pending", 16'h0001, rd);
    chkBit("irq masked", 1'b0, tripIrq);
    regWrite(1'b0, OFS_IRQ_ENABLE_TWO, 16'h0001);
    #1;
    chkBit("irq enabled", 1'b1, tripIrq);
    regWrite(1'b0, OFS_IRQ_PENDING_TWO, 16'h0001);
    regRead(1'b0, OFS_IRQ_PENDING_TWO, rd);
    chkVal("pending cleared", 16'h0000, rd);
    chkBit("irq cleared", 1'b0, tripIrq);
    status(1'b1);
    // Threshold boundary and filter coefficient
    arm(16'h1fff, 16'h3f00, 16'h0003, LF_RINGING);
    line.send(8'h3e, 8);
    status(1'b0);
    line.send(8'h40, 8);
    status(1'b1);
    arm(16'h0000, 16'h3600, 16'h0003, LF_RINGING);
    line.send(8'hff, 10);
    status(1'b0);
    arm(16'h0320, 16'h3600, 16'h000b, LF_RINGING);
    line.send(8'hff, 60);
    status(1'b1);
    // Current limit boost on leaving ringing
    regWrite(1'b0, OFS_BOOST_CTRL, 16'h0080);
    repeat (20) @(posedge core_clk);
    regWrite(1'b0, OFS_LINEFEED, 16'h0000);
    countBoost(n);
    chkVal("boost cycles", 16'h0008, n[15:0]);
    regWrite(1'b0, OFS_BOOST_CTRL, 16'h0000);
    regWrite(1'b0, OFS_LINEFEED, {13'h0000, LF_RINGING});
    repeat (20) @(posedge core_clk);
    regWrite(1'b0, OFS_LINEFEED, 16'h0000);
    countBoost(n);
    chkVal("boost off", 16'h0000, n[15:0]);
    summarize();
  end
endmodule
